// file: hdl/psw_pkg.sv
/*
  Shared constants, register map and carrier types of the program
  space window. Assumes one core clock and a synchronous reset.
*/
package psw_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W  = 16;
  localparam int PWORD_W = 24;
  localparam int PAGE_W  = 8;
  localparam int LOW_W   = 15;
  localparam int PADDR_W = PAGE_W + LOW_W;
  localparam int WB_AW   = 8;
  localparam int WB_DW   = 32;
  localparam int CNT_W   = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WIN_BIT      = 15;  // Top effective address bit
  localparam int EN_BIT       = 2;   // Window enable in core_control
  localparam int STAT_BUSY    = 0;
  localparam int STAT_LASTWIN = 1;
  localparam int STAT_CNT_LSB = 16;

  // ---------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [WB_AW-1:0] ADR_CORE_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] ADR_PAGE_SEL  = 8'h04;
  localparam logic [WB_AW-1:0] ADR_STATUS    = 8'h08;
  localparam logic [15:0]      RST_CORE_CTRL = 16'h0000;
  localparam logic [7:0]       RST_PAGE_SEL  = 8'h00;

  // ---------------------------------------------------------------
  // Extra instruction cycles of a window read
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] EXTRA_MOVE     = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_OTHER    = 2'h2;
  localparam logic [CNT_W-1:0] EXTRA_RPT_EDGE = 2'h2;
  localparam logic [CNT_W-1:0] EXTRA_RPT_MID  = 2'h0;

  // ---------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [WB_AW-1:0] adr;
    logic [3:0]       sel;
    logic [WB_DW-1:0] dat;
  } psw_wb_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] ea;
    logic              op_move;
    logic              in_repeat;
    logic              rpt_first;
    logic              rpt_last;
    logic              rpt_int_exit;
    logic              rpt_int_resume;
    logic              tbl_busy;
  } psw_rd_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXTRA, ST_DONE} psw_state_t;

endpackage : psw_pkg

// file: hdl/psw_extra_cnt.sv
/*
  Down counter for the extra instruction cycles of a window read.
  Assumes load is a one-cycle pulse from the window sequencer.
*/
`timescale 1ns/1ps
module psw_extra_cnt
  import psw_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  // Status
  output logic              busy,
  output logic              last
);

  initial begin
    if (W < 2) $error("psw_extra_cnt: W must be at least 2");
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Load or count down to zero
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = count;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign busy = (cnt != '0);
  assign last = (cnt == W'(1));

endmodule : psw_extra_cnt

// file: hdl/psw_regs.sv
/*
  Wishbone classic slave holding core_control, program_page_select
  and the read-only status word. Assumes the master holds a request
  until it samples ack.
*/
`timescale 1ns/1ps
module psw_regs
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Wishbone slave
  input  wire psw_wb_req_t        wb_req,
  output logic [WB_DW-1:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Register fields
  output logic                    window_enable,
  output logic [PAGE_W-1:0]       page_select,
  input  wire logic [WB_DW-1:0]   status
);

  logic [15:0]       core_control;
  logic [15:0]       next_core_control;
  logic [PAGE_W-1:0] next_page_select;
  logic [WB_DW-1:0]  next_dat;
  logic              next_ack;
  logic              take;

  assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;

  // Decode, write lanes and read mux
  always_comb begin
    next_core_control = core_control;
    next_page_select  = page_select;
    next_dat          = '0;
    next_ack          = take;
    if (take) begin
      unique case (wb_req.adr)
        ADR_CORE_CTRL: begin
          next_dat = {16'h0000, core_control};
          if (wb_req.we && wb_req.sel[0]) next_core_control[7:0] = wb_req.dat[7:0];
          if (wb_req.we && wb_req.sel[1]) next_core_control[15:8] = wb_req.dat[15:8];
        end
        ADR_PAGE_SEL: begin
          next_dat = {24'h000000, page_select};
          if (wb_req.we && wb_req.sel[0]) next_page_select = wb_req.dat[PAGE_W-1:0];
        end
        ADR_STATUS: begin
          next_dat = status;
        end
        default: begin
          next_dat = '0;
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      core_control <= RST_CORE_CTRL;
      page_select  <= RST_PAGE_SEL;
      wb_dat_o     <= '0;
      wb_ack_o     <= 1'b0;
    end else begin
      core_control <= next_core_control;
      page_select  <= next_page_select;
      wb_dat_o     <= next_dat;
      wb_ack_o     <= next_ack;
    end
  end

  assign window_enable = core_control[EN_BIT];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  page_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    take && wb_req.we && wb_req.sel[0] && wb_req.adr == ADR_PAGE_SEL
    |=> page_select == $past(wb_req.dat[PAGE_W-1:0]))
    else $error("page select not written");

endmodule : psw_regs

// file: hdl/psw_window_map.sv
/*
  Program space window: maps data reads at the top half of the data
  space onto a selected page of program memory. Assumes the core
  holds its read request stable while core_stall is high, and that
  the program fetch port answers with prog_ack zero or more cycles later.
*/
// Behaviour
// - Window read only when top address bit and enable bit 2 set.
// - Data addresses 8000h and upward map onto the selected program page.
// - Eight-bit page select register picks one of 256 pages.
// - Program address is page select above low fifteen address bits.
// - Low fifteen data address bits pass unchanged to program address.
// - Window read lengthens the instruction by extra cycles.
// - Window read returns the low sixteen bits of the program word.
// - A new window fetch waits while a table read or write runs.
// - Outside repeat loops, move ops take one extra cycle.
// - Outside repeat loops, other ops take two extra cycles.
// - Repeat first, last, interrupt exit and resume add two cycles.
// - Other repeat iterations complete with no extra cycle.
`timescale 1ns/1ps
module psw_window_map
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Wishbone slave
  input  wire psw_wb_req_t        wb_req,
  output logic [WB_DW-1:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Core data read side
  input  wire psw_rd_req_t        rd_req,
  output logic                    win_sel,
  output logic                    core_stall,
  output logic                    rd_done,
  output logic [DATA_W-1:0]       rd_data,
  // Program fetch side
  output logic                    prog_req,
  output logic [PADDR_W-1:0]      prog_addr,
  input  wire logic               prog_ack,
  input  wire logic [PWORD_W-1:0] prog_rdata
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  psw_state_t          state;
  psw_state_t          next_state;
  logic [PADDR_W-1:0]  next_prog_addr;
  logic [DATA_W-1:0]   next_rd_data;
  logic                last_win;
  logic                next_last_win;
  logic [15:0]         win_count;
  logic [15:0]         next_win_count;
  logic                window_enable;
  logic [PAGE_W-1:0]   page_select;
  logic [WB_DW-1:0]    status;
  logic [CNT_W-1:0]    extra;
  logic                cnt_load;
  logic                cnt_busy;
  logic                cnt_last;
  logic                rpt_edge;
  logic                hit;

  // ---------------------------------------------------------------
  // Registers over Wishbone
  // ---------------------------------------------------------------
  // Status word: busy, kind of last read and completed window reads
  always_comb begin
    status                     = '0;
    status[STAT_BUSY]          = (state != ST_IDLE);
    status[STAT_LASTWIN]       = last_win;
    status[STAT_CNT_LSB +: 16] = win_count;
  end

  psw_regs u_regs (
    .mclk          (mclk),
    .rstn          (rstn),
    .wb_req        (wb_req),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .window_enable (window_enable),
    .page_select   (page_select),
    .status        (status)
  );

  // ---------------------------------------------------------------
  // Window decode and extra cycles
  // ---------------------------------------------------------------
  // window routing
  assign hit = rd_req.valid && rd_req.ea[WIN_BIT] && window_enable;
  assign win_sel = hit;

  assign rpt_edge = rd_req.rpt_first || rd_req.rpt_last
                 || rd_req.rpt_int_exit || rd_req.rpt_int_resume;

  // Extra cycles chosen from the operation and loop position
  always_comb begin
    if (rd_req.in_repeat) begin
      extra = rpt_edge ? EXTRA_RPT_EDGE : EXTRA_RPT_MID;
    end else begin
      extra = rd_req.op_move ? EXTRA_MOVE : EXTRA_OTHER;
    end
  end

  psw_extra_cnt #(
    .W (CNT_W)
  ) u_extra (
    .mclk  (mclk),
    .rstn  (rstn),
    .load  (cnt_load),
    .count (extra),
    .busy  (cnt_busy),
    .last  (cnt_last)
  );

  // ---------------------------------------------------------------
  // Window read sequencer
  // ---------------------------------------------------------------
  // A fetch already issued runs to its end even if a table operation
  // starts; only a new window fetch waits for the table to finish.
  // Extra cycles are counted from the fetch answer, so a slow program
  // memory lengthens the read on top of them.
  // Next state, fetch address and captured data
  always_comb begin
    next_state     = state;
    next_prog_addr = prog_addr;
    next_rd_data   = rd_data;
    next_last_win  = last_win;
    next_win_count = win_count;
    cnt_load       = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (hit && !rd_req.tbl_busy) begin
          next_prog_addr = {page_select, rd_req.ea[LOW_W-1:0]};
          next_state     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (prog_ack) begin
          next_rd_data   = prog_rdata[DATA_W-1:0];
          cnt_load       = 1'b1;
          next_state     = (extra == '0) ? ST_DONE : ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (cnt_last) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_last_win  = 1'b1;
        next_win_count = win_count + 16'h0001;
        next_state     = ST_IDLE;
      end
    endcase
    if (rd_req.valid && !hit && state == ST_IDLE) next_last_win = 1'b0;
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      prog_addr <= '0;
      rd_data   <= '0;
      last_win  <= 1'b0;
      win_count <= 16'h0000;
    end else begin
      state     <= next_state;
      prog_addr <= next_prog_addr;
      rd_data   <= next_rd_data;
      last_win  <= next_last_win;
      win_count <= next_win_count;
    end
  end

  // Handshake outputs
  assign prog_req   = (state == ST_FETCH);
  assign rd_done    = (state == ST_DONE) || (rd_req.valid && !hit && state == ST_IDLE);
  assign core_stall = hit && (state != ST_DONE);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  fetch_cause_a: assert property (
    $rose(prog_req) |-> $past(window_enable && rd_req.valid && rd_req.ea[WIN_BIT]))
    else $error("fetch without enabled window read");

  upper_half_a: assert property (
    state == ST_IDLE && hit && !rd_req.tbl_busy |=> prog_req)
    else $error("upper half read not sent to program memory");

  page_bits_a: assert property (
    $rose(prog_req) |-> prog_addr[PADDR_W-1:LOW_W] == $past(page_select))
    else $error("page bits wrong in program address");

  low_bits_a: assert property (
    $rose(prog_req) |-> prog_addr[LOW_W-1:0] == $past(rd_req.ea[LOW_W-1:0]))
    else $error("low address bits changed");

  win_stretch_a: assert property (
    state == ST_IDLE && hit |-> !rd_done ##1 core_stall)
    else $error("window read finished without stretch");

  low_word_a: assert property (
    state == ST_FETCH && prog_ack |=> rd_data == $past(prog_rdata[DATA_W-1:0]))
    else $error("window data not low program bits");

  table_hold_a: assert property (
    state == ST_IDLE && rd_req.tbl_busy |=> !prog_req)
    else $error("window fetch during table operation");

  move_extra_a: assert property (
    state == ST_FETCH && prog_ack && !rd_req.in_repeat && rd_req.op_move
    |=> state == ST_EXTRA ##1 state == ST_DONE)
    else $error("move op extra cycles wrong");

  other_extra_a: assert property (
    state == ST_FETCH && prog_ack && !rd_req.in_repeat && !rd_req.op_move
    |=> (state == ST_EXTRA) [*2] ##1 state == ST_DONE)
    else $error("other op extra cycles wrong");

  rpt_edge_a: assert property (
    state == ST_FETCH && prog_ack && rd_req.in_repeat && rpt_edge
    |=> (state == ST_EXTRA) [*2] ##1 state == ST_DONE)
    else $error("repeat edge extra cycles wrong");

  rpt_mid_a: assert property (
    state == ST_FETCH && prog_ack && rd_req.in_repeat && !rpt_edge
    |=> state == ST_DONE ##1 state == ST_IDLE)
    else $error("repeat middle iteration stretched");

  plain_read_a: assert property (
    state == ST_IDLE && rd_req.valid && !hit |-> rd_done && !core_stall && !cnt_busy)
    else $error("plain data read stalled");

  fetch_hold_a: assert property (
    prog_req && !prog_ack
    |=> prog_req && $stable(prog_addr))
    else $error("fetch address moved before answer");

  fetch_once_a: assert property (
    prog_req && prog_ack
    |=> !prog_req)
    else $error("second fetch for one window read");

  stall_hold_a: assert property (
    state == ST_FETCH && hit
    |-> core_stall && !rd_done)
    else $error("window read released during fetch");

  low_half_a: assert property (
    state == ST_IDLE && rd_req.valid && !rd_req.ea[WIN_BIT]
    |=> !prog_req)
    else $error("lower half read sent to program memory");

  win_off_a: assert property (
    state == ST_IDLE && !window_enable
    |=> !prog_req)
    else $error("fetch with window disabled");

  data_hold_a: assert property (
    !(state == ST_FETCH && prog_ack)
    |=> $stable(rd_data))
    else $error("read data changed without fetch answer");

  done_free_a: assert property (
    state == ST_DONE
    |-> rd_done && !core_stall)
    else $error("done cycle still stalled");

  tbl_stall_a: assert property (
    state == ST_IDLE && hit && rd_req.tbl_busy
    |-> core_stall && !rd_done)
    else $error("window read released during table operation");

  count_step_a: assert property (
    state == ST_DONE
    |=> win_count == $past(win_count) + 16'h0001)
    else $error("window read count not advanced");

  // ---------------------------------------------------------------
  // Scenario covers
  // ---------------------------------------------------------------
  slow_fetch_c: cover property (prog_req && !prog_ack ##1 prog_req && prog_ack);
  win_read_c: cover property (state == ST_FETCH && prog_ack ##1 state == ST_EXTRA);
  tbl_wait_c: cover property (hit && rd_req.tbl_busy && state == ST_IDLE);
  rpt_mid_c:  cover property (state == ST_FETCH && prog_ack && rd_req.in_repeat && !rpt_edge);
  plain_c:    cover property (rd_req.valid && !hit && rd_done);

endmodule : psw_window_map

// file: sim/psw_prog_model.sv
/*
  Program flash fetch model for the program space window.
  Assumes prog_req is held until the edge at which prog_ack is high.
*/
`timescale 1ns/1ps
module psw_prog_model
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Fetch port
  input  wire logic               prog_req,
  input  wire logic [PADDR_W-1:0] prog_addr,
  output logic                    prog_ack,
  output logic [PWORD_W-1:0]      prog_rdata,
  // Answer delay in cycles
  input  wire logic [1:0]         wait_cycles
);
  logic [1:0] wcnt;
  logic [7:0] noise;

  // Wait counter and idle noise
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      noise <= 8'h00;
      wcnt  <= 2'h0;
    end else begin
      noise <= noise + 8'h01;
      if (!prog_req || prog_ack) begin
        wcnt <= 2'h0;
      end else begin
        wcnt <= wcnt + 2'h1;
      end
    end
  end

  // Answer, a word made from the address or a changing pattern when idle
  assign prog_ack = prog_req && (wcnt == wait_cycles);
  assign prog_rdata = prog_ack ? {8'hff, prog_addr[22:7] ^ prog_addr[15:0]} : {3{noise ^ 8'ha5}};
endmodule : psw_prog_model

// file: sim/psw_window_map_tb.sv
/*
  Self-checking bench of the program space window.
  Assumes the window map and the program flash model beside it.
*/
`timescale 1ns/1ps
module psw_window_map_tb
  import psw_pkg::*;
;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  psw_wb_req_t        wb_req = '0;
  psw_rd_req_t        rd_req = '0;
  logic [WB_DW-1:0]   wb_dat_o, q;
  logic               wb_ack_o, win_sel, core_stall, rd_done, prog_req, prog_ack;
  logic [DATA_W-1:0]  rd_data;
  logic [PADDR_W-1:0] prog_addr;
  logic [PWORD_W-1:0] prog_rdata;
  logic [1:0]         lat = 2'h0;
  logic [7:0]         page;
  int                 fail_count = 0;
  int                 tests_run = 0;

  always #50 mclk = ~mclk;

  psw_window_map i_psw_window_map (.mclk(mclk), .rstn(rstn), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rd_req(rd_req), .win_sel(win_sel), .core_stall(core_stall), .rd_done(rd_done),
    .rd_data(rd_data), .prog_req(prog_req), .prog_addr(prog_addr), .prog_ack(prog_ack), .prog_rdata(prog_rdata));
  psw_prog_model i_psw_prog_model (.mclk(mclk), .rstn(rstn), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_ack(prog_ack), .prog_rdata(prog_rdata), .wait_cycles(lat));

  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic Wishbone single cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    psw_wb_req_t w;
    int          n;
    w = '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    n = 0;
    @(posedge mclk);
    wb_req <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_req <= '0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask : wb

  // One core read; rp = {in_repeat, first, last, int_exit, int_resume}
  task automatic read_op(input logic [15:0] ea, input logic mv, input logic [4:0] rp, input logic hit,
                         input int extra, input int tb);
    psw_rd_req_t r;
    logic [22:0] a;
    int          n;
    r = '0;
    r.valid = 1'b1;
    r.ea = ea;
    r.op_move = mv;
    r.tbl_busy = (tb > 0);
    {r.in_repeat, r.rpt_first, r.rpt_last, r.rpt_int_exit, r.rpt_int_resume} = rp;
    a = {page, ea[14:0]};
    @(posedge mclk);
    rd_req <= r;
    #1;
    check("win_sel", win_sel, hit);
    check("core_stall", core_stall, hit);
    for (int i = 0; i < tb; i++) begin
      check("tbl_prog_req", prog_req, 0);
      @(posedge mclk);
      #1;
      check("tbl_stall", core_stall, 1);
    end
    if (tb > 0) begin
      @(posedge mclk);
      rd_req.tbl_busy <= 1'b0;
      #1;
    end
    n = 0;
    while (rd_done !== 1'b1 && n < 40) begin
      if (prog_req === 1'b1) check("prog_addr", prog_addr, a);
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      conclude();
    end
    check("done_cycle", n, hit ? 2 + lat + extra : 0);
    if (hit) check("rd_data", rd_data, a[22:7] ^ a[15:0]);
    @(posedge mclk);
    rd_req <= '0;
  endtask : read_op

  // Register reset values, access and unmapped place
  task automatic test_regs();
    wb(0, ADR_CORE_CTRL, 0);
    check("core_rst", q, RST_CORE_CTRL);
    wb(0, ADR_PAGE_SEL, 0);
    check("page_rst", q, RST_PAGE_SEL);
    wb(1, ADR_PAGE_SEL, 32'h0000_00a5);
    wb(0, ADR_PAGE_SEL, 0);
    check("page_rw", q, 32'h0000_00a5);
    wb(1, 8'h0c, 32'hffff_ffff);
    wb(0, 8'h0c, 0);
    check("unmapped", q, 0);
    page = 8'ha5;
    $display("Test regs done");
  endtask : test_regs

  // Plain reads: enable clear, then low half with enable set
  task automatic test_plain();
    read_op(16'h8000, 0, 0, 0, 0, 0);
    wb(1, ADR_CORE_CTRL, 32'h0000_0004);
    wb(0, ADR_CORE_CTRL, 0);
    check("core_rw", q, 32'h0000_0004);
    read_op(16'h7fff, 1, 0, 0, 0, 0);
    $display("Test plain done");
  endtask : test_plain

  // Extra cycles for every kind of window read
  task automatic test_window();
    logic [15:0] eas[7] = '{16'h8000, 16'hffff, 16'h9234, 16'ha001, 16'hc5a5, 16'hd00e, 16'hbeef};
    logic [5:0]  ops[7] = '{6'h00, 6'h20, 6'h38, 6'h34, 6'h32, 6'h31, 6'h30};
    int          ext[7] = '{1, 2, 2, 2, 2, 2, 0};
    for (int i = 0; i < 7; i++) begin
      read_op(eas[i], ~ops[i][5] & (i == 0 || i > 1), ops[i][4:0], 1, ext[i], 0);
    end
    for (int i = 0; i < 2; i++) begin
      page = (i == 0) ? 8'h00 : 8'hff;
      wb(1, ADR_PAGE_SEL, {24'h0, page});
      read_op(eas[1 - i], 0, 0, 1, 2, 0);
    end
    $display("Test window done");
  endtask : test_window

  // Slow fetch, table suspension and status count
  task automatic test_slow_tbl();
    lat <= 2'h2;
    read_op(16'h8765, 1, 0, 1, 1, 0);
    lat <= 2'h0;
    read_op(16'hf00d, 0, 0, 1, 2, 3);
    wb(0, ADR_STATUS, 0);
    check("status", q, 32'h000b_0002);
    $display("Test slow_tbl done");
  endtask : test_slow_tbl

  initial begin
    page = 8'h00;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    test_regs();
    test_plain();
    test_window();
    test_slow_tbl();
    conclude();
  end
endmodule : psw_window_map_tb
